// >>> include/dacuc_cfg.svh
`ifndef DACUC_CFG_SVH
`define DACUC_CFG_SVH

`define DACUC_CODE_W 12
`define DACUC_BYTE_W 8
`define DACUC_HI_W 4
`define DACUC_CODE_RST 12'h000
`define DACUC_TWOS_ZERO 12'h800
`define DACUC_SIGN_BIT 11
`define DACUC_NCH 2

`endif

// >>> include/dacuc_pkg.sv
package dacuc_pkg;
  typedef enum logic [1:0] {
    DACUC_IDLE,
    DACUC_WAIT,
    DACUC_LOAD
  } dacuc_ch_state_t;
  typedef logic [11:0] dacuc_code_t;
endpackage

// >>> src/dacuc_edge_sync.sv
`timescale 1ns/10ps
`include "dacuc_cfg.svh"
module dacuc_edge_sync
  import dacuc_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic async_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Two flip-flops before any logic reads the pin.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      last_r <= 1'b1;
    end else begin
      meta_r <= async_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise = sync_r & ~last_r;
  assign fall = ~sync_r & last_r;
endmodule

// >>> src/dacuc_top.sv
`timescale 1ns/10ps
`include "dacuc_cfg.svh"
module dacuc_top
  import dacuc_pkg::*;
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic [7:0] DATA_IN,
  input wire logic CH0_LO_WR,
  input wire logic CH0_HI_WR,
  input wire logic CH1_LO_WR,
  input wire logic CH1_HI_WR,
  input wire logic CH0_TIMED_UPDATE_SEL,
  input wire logic CH1_TIMED_UPDATE_SEL,
  input wire logic OUTPUT_TWOS_COMP_SEL,
  input wire logic TIMER_IRQ_ENABLE,
  input wire logic TIMER_FLAG_CLR,
  input wire logic EXT_UPDATE_N,
  input wire logic UPDATE_COUNTER_OUT,
  output logic [11:0] CONVERTER_CH0,
  output logic [11:0] CONVERTER_CH1,
  output logic [1:0] CONVERTER_LOAD,
  output logic TIMER_EVENT_FLAG,
  output logic TIMER_IRQ
);
  logic ext_level;
  logic ext_rise;
  logic cnt_level;
  logic cnt_rise;
  logic upd_low;
  logic upd_low_edge;
  logic upd_low_last_r;
  logic flag_r;
  logic [`DACUC_NCH-1:0] lo_wr;
  logic [`DACUC_NCH-1:0] hi_wr;
  logic [`DACUC_NCH-1:0] tsel;
  logic [`DACUC_NCH-1:0] load_r;
  dacuc_code_t conv_r [`DACUC_NCH];

  dacuc_edge_sync u_ext (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .async_in(EXT_UPDATE_N),
    .level(ext_level),
    .rise(ext_rise),
    .fall()
  );

  dacuc_edge_sync u_cnt (
    .clock(CLOCK),
    .arst_n(ARST_N),
    .async_in(UPDATE_COUNTER_OUT),
    .level(cnt_level),
    .rise(cnt_rise),
    .fall()
  );

  // An update occurs when either source shows a low level.
  assign upd_low = ~ext_level | ~cnt_level;
  assign upd_low_edge = upd_low & ~upd_low_last_r;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      upd_low_last_r <= 1'b0;
    end else begin
      upd_low_last_r <= upd_low;
    end
  end

  assign lo_wr = {CH1_LO_WR, CH0_LO_WR};
  assign hi_wr = {CH1_HI_WR, CH0_HI_WR};
  assign tsel = {CH1_TIMED_UPDATE_SEL, CH0_TIMED_UPDATE_SEL};

  genvar g;
  generate
    for (g = 0; g < `DACUC_NCH; g = g + 1) begin : g_ch
      dacuc_code_t buf_r;
      dacuc_code_t coded;
      logic pend_r;
      logic wr_any;

      assign wr_any = lo_wr[g] | hi_wr[g];
      // Two's complement codes shift to offset binary for the converter.
      assign coded = OUTPUT_TWOS_COMP_SEL ?
        (buf_r ^ `DACUC_TWOS_ZERO) : buf_r;

      // First stage holds the code assembled from its two bytes.
      always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          buf_r <= `DACUC_CODE_RST;
        end else if (lo_wr[g]) begin
          buf_r[7:0] <= DATA_IN;
        end else if (hi_wr[g]) begin
          buf_r[11:8] <= DATA_IN[3:0];
        end
      end

      // Timed mode remembers a write until the next update level.
      always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          pend_r <= 1'b0;
        end else if (wr_any) begin
          pend_r <= tsel[g];
        end else if (upd_low) begin
          pend_r <= 1'b0;
        end
      end

      // Second stage drives the converter of this channel only.
      always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
          conv_r[g] <= `DACUC_TWOS_ZERO ^ `DACUC_TWOS_ZERO;
          load_r[g] <= 1'b0;
        end else if (!tsel[g] && wr_any) begin
          conv_r[g] <= OUTPUT_TWOS_COMP_SEL ?
            ((lo_wr[g] ? {buf_r[11:8], DATA_IN} :
              {DATA_IN[3:0], buf_r[7:0]}) ^ `DACUC_TWOS_ZERO) :
            (lo_wr[g] ? {buf_r[11:8], DATA_IN} :
             {DATA_IN[3:0], buf_r[7:0]});
          load_r[g] <= 1'b1;
        end else if (tsel[g] && upd_low && (pend_r || upd_low_edge)) begin
          conv_r[g] <= coded;
          load_r[g] <= 1'b1;
        end else begin
          load_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Status flag: a rising edge sets it and wins over a clear.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      flag_r <= 1'b0;
    end else if (ext_rise || cnt_rise) begin
      flag_r <= 1'b1;
    end else if (TIMER_FLAG_CLR) begin
      flag_r <= 1'b0;
    end
  end

  assign CONVERTER_CH0 = conv_r[0];
  assign CONVERTER_CH1 = conv_r[1];
  assign CONVERTER_LOAD = load_r;
  assign TIMER_EVENT_FLAG = flag_r;
  assign TIMER_IRQ = flag_r & TIMER_IRQ_ENABLE;
endmodule

// >>> tb/dacuc_upd_src.sv
`timescale 1ns/10ps
module dacuc_upd_src #(parameter int N = 5) (
  input wire logic clock,
  input wire logic run,
  output logic cnt_out = 1'b1
);
  int c = 0;
  always @(negedge clock) begin
    c <= run && c < N - 1 ? c + 1 : 0;
    cnt_out <= !(run && c == N - 1);
  end
endmodule

// >>> tb/dacuc_top_sva.sv
`timescale 1ns/10ps
module dacuc_top_sva (
  input wire logic CLOCK, ARST_N, CH0_LO_WR, CH1_LO_WR, CH1_HI_WR,
  input wire logic CH0_TIMED_UPDATE_SEL, CH1_TIMED_UPDATE_SEL,
  input wire logic TIMER_IRQ_ENABLE, TIMER_FLAG_CLR, EXT_UPDATE_N,
  input wire logic UPDATE_COUNTER_OUT, TIMER_EVENT_FLAG, TIMER_IRQ,
  input wire logic [7:0] DATA_IN,
  input wire logic [11:0] CONVERTER_CH0,
  input wire logic [1:0] CONVERTER_LOAD
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  property p_irq; TIMER_IRQ == (TIMER_EVENT_FLAG && TIMER_IRQ_ENABLE);
  endproperty
  a_irq: assert property (p_irq) else $error("irq");
  property p_en; !TIMER_IRQ_ENABLE |-> !TIMER_IRQ; endproperty
  a_en: assert property (p_en) else $error("en");
  property p_hold; TIMER_EVENT_FLAG && !TIMER_FLAG_CLR |=> TIMER_EVENT_FLAG;
  endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_ext; $rose(EXT_UPDATE_N) |-> ##[1:4] TIMER_EVENT_FLAG;
  endproperty
  a_ext: assert property (p_ext) else $error("ext");
  property p_cnt; $rose(UPDATE_COUNTER_OUT) |-> ##[1:4] TIMER_EVENT_FLAG;
  endproperty
  a_cnt: assert property (p_cnt) else $error("cnt");
  property p_lo0; CH0_LO_WR && !CH0_TIMED_UPDATE_SEL |=>
    CONVERTER_LOAD[0] && CONVERTER_CH0[7:0] == $past(DATA_IN); endproperty
  a_lo0: assert property (p_lo0) else $error("lo0");
  property p_no1; !CH1_LO_WR && !CH1_HI_WR && !CH1_TIMED_UPDATE_SEL |=>
    !CONVERTER_LOAD[1]; endproperty
  a_no1: assert property (p_no1) else $error("no1");
  property p_buf; (CH0_TIMED_UPDATE_SEL && EXT_UPDATE_N &&
    UPDATE_COUNTER_OUT)[*4] |=> !CONVERTER_LOAD[0]; endproperty
  a_buf: assert property (p_buf) else $error("buf");
endmodule
bind dacuc_top dacuc_top_sva dacuc_top_sva_inst (.*);

// >>> tb/dacuc_top_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
n_mismatch++; $display("MISMATCH %0t bad value", $time); end end
module dacuc_top_test;
  logic CLOCK = 0, ARST_N = 0, CH0_LO_WR = 0, CH0_HI_WR = 0, run = 0;
  logic CH1_LO_WR = 0, CH1_HI_WR = 0, CH0_TIMED_UPDATE_SEL = 0;
  logic CH1_TIMED_UPDATE_SEL = 0, OUTPUT_TWOS_COMP_SEL = 0;
  logic TIMER_IRQ_ENABLE = 0, TIMER_FLAG_CLR = 0, EXT_UPDATE_N = 1;
  logic [7:0] DATA_IN = 0;
  logic [11:0] CONVERTER_CH0, CONVERTER_CH1;
  logic [1:0] CONVERTER_LOAD;
  logic UPDATE_COUNTER_OUT, TIMER_EVENT_FLAG, TIMER_IRQ;
  int n_mismatch = 0, samples_checked = 0;
  dacuc_top dacuc_top_inst (.*);
  dacuc_upd_src dacuc_upd_src_inst (.clock(CLOCK), .run(run),
    .cnt_out(UPDATE_COUNTER_OUT));
  initial forever #50 CLOCK = ~CLOCK;
  initial begin
    #20000;
    n_mismatch++;
    print_verdict;
  end
  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task wr(input logic [3:0] s, input logic [7:0] d);
    {CH1_HI_WR, CH1_LO_WR, CH0_HI_WR, CH0_LO_WR} = s;
    DATA_IN = d;
    @(negedge CLOCK);
  endtask
  task t_imm;
    wr(4'h1, 8'h34);
    `CHK(CONVERTER_LOAD, 2'h1)
    wr(4'h2, 8'hff);
    OUTPUT_TWOS_COMP_SEL = 1;
    wr(4'h8, 8'h07);
    `CHK(CONVERTER_LOAD, 2'h2)
    `CHK(CONVERTER_CH0, 12'hf34)
    wr(4'h0, 8'h00);
    `CHK(CONVERTER_CH1, 12'hf00)
  endtask
  task t_timed;
    CH0_TIMED_UPDATE_SEL = 1;
    wr(4'h1, 8'h12);
    wr(4'h0, 8'h00);
    `CHK(CONVERTER_CH0, 12'hf34)
    EXT_UPDATE_N = 0;
    repeat (4) @(negedge CLOCK);
    `CHK({CONVERTER_CH0, TIMER_EVENT_FLAG}, 13'he24)
    EXT_UPDATE_N = 1;
    repeat (4) @(negedge CLOCK);
    `CHK({TIMER_EVENT_FLAG, TIMER_IRQ}, 2'h2)
    TIMER_IRQ_ENABLE = 1;
    #1 `CHK(TIMER_IRQ, 1'b1)
    TIMER_FLAG_CLR = 1;
    @(negedge CLOCK) TIMER_FLAG_CLR = 0;
    @(negedge CLOCK) `CHK(TIMER_EVENT_FLAG, 1'b0)
  endtask
  task t_cnt;
    CH1_TIMED_UPDATE_SEL = 1;
    wr(4'h4, 8'h55);
    wr(4'h0, 8'h00);
    `CHK(CONVERTER_CH1, 12'hf00)
    run = 1;
    repeat (12) @(negedge CLOCK);
    `CHK({CONVERTER_CH1, TIMER_EVENT_FLAG}, 13'h1eab)
  endtask
  initial begin
    repeat (12) @(negedge CLOCK);
    ARST_N = 1;
    t_imm;
    t_timed;
    t_cnt;
    print_verdict;
  end
endmodule
